// ==== hdl/gpio_query_regs.svh ====
`ifndef GPIO_QUERY_REGS_SVH
`define GPIO_QUERY_REGS_SVH

// Command codes and reply framing
`define CMD_READ_PIN    8'h23
`define REPLY_FLAG      8'h40
`define REPLY_LEN       4
`define NUM_PINS        5

// Second reply byte field positions
`define LVL_BIT         0
`define FALL_BIT        1
`define RISE_BIT        2

// Requested level limits
`define DUTY_LOW        8'h00
`define DUTY_HIGH       8'h64

// Drive mode encodings
`define DRV_UP_PULLDN   3'h0
`define DRV_UP_DN       3'h1
`define DRV_HIZ         3'h2
`define DRV_PULLUP_DN   3'h3
`define DRV_SLOW_UP_HIZ 3'h4
`define DRV_SLOW_UP_DN  3'h5
`define DRV_RESERVED    3'h6
`define DRV_HIZ_SLOW_DN 3'h7

// Timing
`define CLK_HZ          200000000
`define SAMPLE_HZ       32
`define PWM_HZ          100
`define PWM_STEPS       100

// Reset values
`define STATE_RST       '0

`endif

// ==== hdl/gpio_query_pkg.sv ====
package gpio_query_pkg;

   typedef struct packed {
      logic [7:0] level;   // Requested duty 0..100
      logic       func;    // 1: user control, 0: default role
      logic [2:0] mode;    // Drive mode
   } pin_cfg_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] idx;
   } query_req_t;

   typedef struct packed {
      logic [7:0] typ;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [7:0] d3;
   } query_rsp_t;

   typedef struct packed {
      logic o;      // Driven value
      logic oe;     // Strong driver on
      logic pu;     // Resistive pull-up on
      logic pd;     // Resistive pull-down on
      logic slow;   // Slow slew
   } drive_t;

   typedef struct packed {
      logic [4:0]   sync1;
      logic [4:0]   sync2;
      logic [4:0]   level;
      logic [4:0]   fall;
      logic [4:0]   rise;
      logic [23:0]  sample_cnt;
      logic [15:0]  pwm_div;
      logic [6:0]   pwm_phase;
      logic         rsp_valid;
      query_rsp_t   rsp;
      drive_t [4:0] drv;
   } state_t;

endpackage : gpio_query_pkg

// ==== hdl/gpio_level_config_query.sv ====
// What this block does
// (RULE_01) Command 35 queries pin index 0..4
// (RULE_02) Reply code ORs 0x40, echoes index
// (RULE_03) Second byte bit 0: last sampled level
// (RULE_04) Bit 1: falling edge since last query
// (RULE_05) Bit 2: rising edge; upper bits reserved
// (RULE_06) Level is real pin, not commanded value
// (RULE_07) Sample all pins near 32 Hz freely
// (RULE_08) Third byte: stored requested duty 0..100
// (RULE_09) Fourth byte low three bits: drive mode
// (RULE_10) Fourth byte bit 3: function select
// (RULE_11) Fourth byte upper bits read zero
// (RULE_12) Default roles: sense, power, reset, one-wire
// (RULE_13) 0 low, 100 high, else 100 Hz PWM
// (RULE_14) Clear edge flags after reporting them
`timescale 1ns/1ps
`include "gpio_query_regs.svh"

module gpio_level_config_query
   import gpio_query_pkg::*;
#(
   parameter int SAMPLE_CYCLES   = `CLK_HZ / `SAMPLE_HZ,
   parameter int PWM_STEP_CYCLES = `CLK_HZ / (`PWM_HZ * `PWM_STEPS)
)(
   input  wire logic                  clk,              // 200 MHz clock
   input  wire logic                  sys_rst,          // Synchronous reset, active high
   input  wire logic                  req_valid,        // Query packet present, one cycle
   input  wire query_req_t            req,              // Command code and pin index
   output      logic                  rsp_valid,        // Reply present, one cycle
   output      query_rsp_t            rsp,              // Reply code and four data bytes
   input  wire pin_cfg_t [4:0]        pin_cfg,          // Stored level, function, mode per pin
   input  wire logic     [4:0]        default_lvl,      // Level wanted by default-role logic
   input  wire logic     [4:0]        pin_i,            // Pin levels, asynchronous
   output      drive_t   [4:0]        pin_drv,          // Pin driver controls
   output      logic                  host_power_sense, // Sampled level of pin 1
   output      logic                  one_wire_rx       // Synchronised level of pin 4
);

   localparam int NP = `NUM_PINS;

   generate
      if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 16777216) begin : g_bad_sample
         $error("SAMPLE_CYCLES does not fit the sample counter");
      end
      if (PWM_STEP_CYCLES < 1 || PWM_STEP_CYCLES > 65536) begin : g_bad_pwm
         $error("PWM_STEP_CYCLES does not fit the PWM divider");
      end
   endgenerate

   state_t     st_r;
   state_t     st_nxt;
   logic [2:0] qi;
   logic       req_ok;
   logic       sample_tick;
   logic       pwm_tick;

   assign qi          = req.idx[2:0];
   assign req_ok      = req_valid && (req.cmd == `CMD_READ_PIN) && (req.idx < 8'(NP)); // RULE_01
   assign sample_tick = (st_r.sample_cnt == 24'h000000);
   assign pwm_tick    = (st_r.pwm_div == 16'h0000);

   // Translate the wanted level through the drive mode table
   function automatic drive_t drive_of(input logic [2:0] mode, input logic lvl);
      drive_t d;
      d = '0;
      case (mode) // RULE_09
         `DRV_UP_PULLDN: begin
            d.oe = lvl;
            d.o  = lvl;
            d.pd = ~lvl;
         end
         `DRV_UP_DN: begin
            d.oe = 1'b1;
            d.o  = lvl;
         end
         `DRV_HIZ: begin
            d = '0;
         end
         `DRV_PULLUP_DN: begin
            d.pu = lvl;
            d.oe = ~lvl;
            d.o  = 1'b0;
         end
         `DRV_SLOW_UP_HIZ: begin
            d.oe   = lvl;
            d.o    = 1'b1;
            d.slow = 1'b1;
         end
         `DRV_SLOW_UP_DN: begin
            d.oe   = 1'b1;
            d.o    = lvl;
            d.slow = 1'b1;
         end
         `DRV_HIZ_SLOW_DN: begin
            d.oe   = ~lvl;
            d.o    = 1'b0;
            d.slow = 1'b1;
         end
         default: begin
            // Reserved code leaves the pin floating rather than guessing
            d = '0;
         end
      endcase
      return d;
   endfunction : drive_of

   always_comb begin
      logic lvl;
      lvl    = 1'b0;
      st_nxt = st_r;

      // Two-stage synchroniser; only the second stage feeds logic
      st_nxt.sync1 = pin_i;
      st_nxt.sync2 = st_r.sync1;

      // Free-running sample timer, unrelated to queries
      if (sample_tick) begin
         st_nxt.sample_cnt = 24'(SAMPLE_CYCLES - 1); // RULE_07
      end else begin
         st_nxt.sample_cnt = st_r.sample_cnt - 24'h000001;
      end

      // Reply and flag clearing
      st_nxt.rsp_valid = 1'b0;
      if (req_ok) begin
         st_nxt.rsp_valid = 1'b1;
         st_nxt.rsp.typ   = `CMD_READ_PIN | `REPLY_FLAG; // RULE_02
         st_nxt.rsp.d0    = req.idx; // RULE_02
         st_nxt.rsp.d1    = 8'h00; // RULE_05
         st_nxt.rsp.d1[`LVL_BIT]  = st_r.level[qi]; // RULE_03
         st_nxt.rsp.d1[`FALL_BIT] = st_r.fall[qi]; // RULE_04
         st_nxt.rsp.d1[`RISE_BIT] = st_r.rise[qi]; // RULE_05
         st_nxt.rsp.d2    = pin_cfg[qi].level; // RULE_08
         st_nxt.rsp.d3    = {4'h0, pin_cfg[qi].func, pin_cfg[qi].mode}; // RULE_09 RULE_10 RULE_11
         st_nxt.fall[qi]  = 1'b0; // RULE_14
         st_nxt.rise[qi]  = 1'b0; // RULE_14
      end

      // Sampling after the clear, so an edge seen this cycle survives
      if (sample_tick) begin
         st_nxt.level = st_r.sync2; // RULE_06
         st_nxt.fall  = st_nxt.fall | (st_r.level & ~st_r.sync2); // RULE_04
         st_nxt.rise  = st_nxt.rise | (~st_r.level & st_r.sync2); // RULE_05
      end

      // PWM step timer and phase 0..99
      if (pwm_tick) begin
         st_nxt.pwm_div = 16'(PWM_STEP_CYCLES - 1);
         if (st_r.pwm_phase == 7'(`PWM_STEPS - 1)) begin
            st_nxt.pwm_phase = 7'h00;
         end else begin
            st_nxt.pwm_phase = st_r.pwm_phase + 7'h01;
         end
      end else begin
         st_nxt.pwm_div = st_r.pwm_div - 16'h0001;
      end

      // Pin drive; default-role pins follow the logic that owns them
      for (int p = 0; p < NP; p++) begin
         if (pin_cfg[p].func) begin
            // Values above 100 are invalid; treated as steady high
            lvl = ({1'b0, st_r.pwm_phase} < pin_cfg[p].level); // RULE_13
         end else begin
            lvl = default_lvl[p]; // RULE_12
         end
         st_nxt.drv[p] = drive_of(pin_cfg[p].mode, lvl);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= `STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rsp_valid        = st_r.rsp_valid;
   assign rsp              = st_r.rsp;
   assign pin_drv          = st_r.drv;
   assign host_power_sense = st_r.level[1]; // RULE_12
   assign one_wire_rx      = st_r.sync2[4]; // RULE_12

   // Checks
   reply_code_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
      rsp_valid |-> (rsp.typ == 8'h63))
      else $error("reply code is not 0x63");

   reply_echo_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
      req_ok |=> (rsp_valid && rsp.d0 == $past(req.idx)))
      else $error("reply missing or index not echoed");

   bad_index_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
      (req_valid && req.idx >= 8'h05) |=> !rsp_valid)
      else $error("reserved index answered");

   level_bit_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
      req_ok |=> (rsp.d1[0] == $past(st_r.level[qi])))
      else $error("level bit differs from last sample");

   reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
      rsp_valid |-> (rsp.d1[7:3] == 5'h00 && rsp.d3[7:4] == 4'h0))
      else $error("reserved reply bits not zero");

   flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
      (req_ok && !sample_tick) |=> (st_r.fall[$past(qi)] == 1'b0 && st_r.rise[$past(qi)] == 1'b0))
      else $error("edge flags not cleared after reply");

   flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
      (sample_tick && st_r.level[0] && !st_r.sync2[0]) |=> st_r.fall[0])
      else $error("falling edge on pin 0 lost");

   sample_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
      !sample_tick |=> (st_r.level == $past(st_r.level)))
      else $error("level changed between samples");

   duty_echo_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
      req_ok |=> (rsp.d2 == $past(pin_cfg[qi].level) && rsp.d3[3] == $past(pin_cfg[qi].func)))
      else $error("duty or function byte wrong");

   pwm_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
      (pin_cfg[0].func && pin_cfg[0].level == `DUTY_LOW && pin_cfg[0].mode == `DRV_UP_DN)
         |=> (pin_drv[0].oe && !pin_drv[0].o))
      else $error("duty 0 did not hold pin 0 low");

   pwm_on_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
      (pin_cfg[0].func && pin_cfg[0].level == `DUTY_HIGH && pin_cfg[0].mode == `DRV_UP_DN)
         |=> (pin_drv[0].oe && pin_drv[0].o))
      else $error("duty 100 did not hold pin 0 high");

endmodule : gpio_level_config_query

// ==== tb/pin_load.sv ====
`timescale 1ns/1ps

module pin_load
   import gpio_query_pkg::*;
(
   input  wire drive_t [4:0] drv,  // Driver controls from the port
   input  wire logic   [4:0] ext,  // Level forced by outside circuitry
   output      logic   [4:0] lvl   // Resolved pin level
);
   // Strong driver beats the pulls, pulls beat a weak outside source
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         lvl[p] = drv[p].oe ? drv[p].o : drv[p].pu ? 1'b1 : drv[p].pd ? 1'b0 : ext[p];
      end
   end
endmodule : pin_load

// ==== tb/gpio_level_config_query_tb.sv ====
`timescale 1ns/1ps

module gpio_level_config_query_tb;
   import gpio_query_pkg::*;

   localparam int SC   = 20;
   localparam logic [39:0] FULL = 40'hFF_FFFF_FFFF;
   localparam logic [39:0] NOFL = 40'hFF_FFF9_FFFF;

   logic            clk, sys_rst, req_valid, rsp_valid, host_power_sense, one_wire_rx;
   query_req_t      req;
   query_rsp_t      rsp;
   pin_cfg_t [4:0]  pin_cfg;
   logic     [4:0]  default_lvl, pin_i, ext, exp_lvl, rf, ff;
   drive_t   [4:0]  pin_drv;
   int              errors, n_checks, seed, cnt;

   gpio_level_config_query #(.SAMPLE_CYCLES(SC), .PWM_STEP_CYCLES(2)) dut (
      .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
      .pin_cfg(pin_cfg), .default_lvl(default_lvl), .pin_i(pin_i), .pin_drv(pin_drv),
      .host_power_sense(host_power_sense), .one_wire_rx(one_wire_rx));

   pin_load load (.drv(pin_drv), .ext(ext), .lvl(pin_i));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report

   // Level seen by the pin when only the bench load competes with the port
   function automatic logic pin_exp(input logic [2:0] m, input logic h, input logic e);
      case (m)
         3'h0, 3'h1, 3'h3, 3'h5: return h;
         3'h4: return h | e;
         3'h7: return h & e;
         default: return e;
      endcase
   endfunction : pin_exp

   // New outside levels, then enough time for sync plus two sample ticks
   task automatic settle(input logic [4:0] e);
      ext = e;
      repeat (3 * SC) @(negedge clk);
      for (int p = 0; p < 5; p++) begin
         if (e[p] != exp_lvl[p]) begin
            rf[p] = rf[p] | e[p];
            ff[p] = ff[p] | ~e[p];
         end
      end
      exp_lvl = e;
   endtask : settle

   // Caller sits at a falling edge; req_valid stays up unless last
   task automatic query(input logic [7:0] c, input logic [7:0] i, input logic [39:0] m, input logic last);
      query_rsp_t e;
      logic       ok;
      e = {8'h63, i, 5'h00, rf[i[2:0]], ff[i[2:0]], exp_lvl[i[2:0]], pin_cfg[i[2:0]].level,
           4'h0, pin_cfg[i[2:0]].func, pin_cfg[i[2:0]].mode};
      ok = (c == 8'h23) && (i < 8'h05);
      req_valid = 1'b1;
      req = '{c, i};
      @(negedge clk);
      if (last) req_valid = 1'b0;
      chk(rsp_valid === ok, "reply strobe");
      if (ok) begin
         chk(((rsp ^ e) & m) === 40'h0, "reply content");
         rf[i[2:0]] = 1'b0;
         ff[i[2:0]] = 1'b0;
      end
   endtask : query

   initial begin
      #300000;
      errors++;
      final_report();
   end

   initial begin
      seed = 90;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      default_lvl = 5'h00;
      ext = 5'h00;
      exp_lvl = 5'h00;
      rf = 5'h00;
      ff = 5'h00;
      for (int p = 0; p < 5; p++) pin_cfg[p] = '{8'h00, 1'b1, 3'h2};
      // Count rising edges so the start-up edge of the clock cannot shorten reset
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      repeat (3 * SC) @(negedge clk);
      for (int r = 0; r < 8; r++) begin
         default_lvl = 5'($random(seed));
         for (int p = 0; p < 5; p++) pin_cfg[p] = '{8'($unsigned($random(seed)) % 101), 1'($random(seed)), 3'h2};
         settle(5'($random(seed)));
         chk(host_power_sense === exp_lvl[1], "power sense level");
         chk(one_wire_rx === exp_lvl[4], "one-wire receive level");
         query(8'h22, 8'h00, FULL, 1'b1);
         query(8'h23, 8'h05, FULL, 1'b1);
         query(8'h23, 8'hFF, FULL, 1'b1);
         for (int p = 0; p < 5; p++) query(8'h23, 8'(p), FULL, 1'b0);
         query(8'h23, 8'h00, FULL, 1'b1);
      end
      // Upper half hands pin 0 back to its default-role level
      for (int m = 0; m < 32; m++) begin
         default_lvl = 5'($random(seed));
         pin_cfg[0] = '{m[0] ? 8'h64 : 8'h00, ~m[4], 3'(m >> 1)};
         ext = 5'($random(seed));
         repeat (3 * SC) @(negedge clk);
         exp_lvl[0] = pin_exp(3'(m >> 1), m[4] ? default_lvl[0] : m[0], ext[0]);
         query(8'h23, 8'h00, NOFL, 1'b1);
      end
      pin_cfg[0] = '{8'h32, 1'b1, 3'h1};
      repeat (20) @(negedge clk);
      cnt = 0;
      repeat (200) begin
         @(negedge clk);
         cnt += pin_drv[0].o;
      end
      chk(cnt >= 98 && cnt <= 102, "pwm duty");
      final_report();
   end
endmodule : gpio_level_config_query_tb
